// ==== hw/split_timer_pkg.sv ====
// How it works
// - The split-mode bit picks one 16-bit auto-reload counter (0) or two 8-bit ones (1).
// - In 16-bit mode a 0xFFFF to 0x0000 rollover loads the 16-bit reload value and sets the high flag.
// - The alternate clock select picks system clock / 12 (0) or external clock / 8 (1).
// - In split mode each byte has a select bit: 1 is system clock, 0 is the alternate clock.
// - The external clock / 8 is synchronised to the system clock before it advances a count.
// - In split mode each byte reloads from its own reload byte when it rolls from 0xFF to 0x00.
// - Run control gates the whole counter in 16-bit mode and only the high byte in split mode.
// - The high overflow flag sets on each high-byte rollover, the full rollover in 16-bit mode.
// - The low overflow flag sets on each low-byte rollover in both modes.
// - With the timer irq enable set, high overflow requests an irq; low too if its enable is set.
// - Counting never clears an overflow flag; only reset or a software write of zero does.
// - Control bits 4 and 1 always read zero and ignore writes.
// - The count registers show the 16-bit count, or two independent bytes in split mode.
// - The high-byte select is ignored outside split mode; there the low-byte select clocks the whole timer.
`default_nettype none

package split_timer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses on the special function register bus
  localparam logic [7:0] CONTROL_ADDR     = 8'hC8;
  localparam logic [7:0] RELOAD_LOW_ADDR  = 8'hCA;
  localparam logic [7:0] RELOAD_HIGH_ADDR = 8'hCB;
  localparam logic [7:0] COUNT_LOW_ADDR   = 8'hCC;
  localparam logic [7:0] COUNT_HIGH_ADDR  = 8'hCD;

  // control register field positions
  localparam int HIGH_FLAG_BIT  = 7;
  localparam int LOW_FLAG_BIT   = 6;
  localparam int LOW_IRQ_EN_BIT = 5;
  localparam int SPLIT_BIT      = 3;
  localparam int RUN_BIT        = 2;
  localparam int XCLK_BIT       = 0;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] RELOAD_RESET  = 8'h00;

  // byte extremes and clock dividers
  localparam logic [7:0] BYTE_MAX  = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int         SYS_DIV   = 12;
  localparam int         EXT_DIV   = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

  // one bus request from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

endpackage : split_timer_pkg

`default_nettype wire

// ==== hw/reload_byte_counter.sv ====
`default_nettype none

// one 8-bit counter byte with write port and wrap-to-reload
module reload_byte_counter
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       inc,
  input  wire logic       wrap_reload,
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  input  wire logic [7:0] reload_value,
  output logic      [7:0] count,
  output logic            wrap
);

  logic [7:0] count_reg;

  assign count = count_reg;
  assign wrap  = inc && !load && (count_reg == split_timer_pkg::BYTE_MAX);

  // a software write wins over a count step in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      count_reg <= split_timer_pkg::COUNT_RESET;
    else if (load)
      count_reg <= load_value;
    else if (wrap)
      count_reg <= wrap_reload ? reload_value : split_timer_pkg::BYTE_ZERO;
    else if (inc)
      count_reg <= count_reg + 8'h01;
  end

  a_wrap_value : assert property (@(posedge clk) disable iff (rst)
    wrap && wrap_reload |=> count_reg == $past(reload_value))
    else $error("byte wrap did not load reload value");

endmodule : reload_byte_counter

`default_nettype wire

// ==== hw/split_autoreload_timer.sv ====
`default_nettype none

module split_autoreload_timer
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire split_timer_pkg::sfr_req_s sfr_req,
  input  wire logic                      timer_irq_enable,
  input  wire logic                      high_byte_clock_select,
  input  wire logic                      low_byte_clock_select,
  input  wire logic                      ext_osc_clk,
  output logic                     [7:0] sfr_rdata,
  output logic                           timer_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic       high_flag_reg;
  logic       low_flag_reg;
  logic       low_irq_en_reg;
  logic       split_reg;
  logic       run_reg;
  logic       xclk_reg;
  logic [7:0] reload_low_reg;
  logic [7:0] reload_high_reg;
  logic [7:0] rdata_reg;
  logic       irq_reg;
  logic [3:0] sys_div_reg;
  logic       sys_tick_reg;
  logic       ext_meta_reg;
  logic       ext_sync_reg;
  logic       ext_prev_reg;
  logic [2:0] ext_div_reg;
  logic       ext_tick_reg;

  logic       wr_ctrl;
  logic       wr_cnt_lo;
  logic       wr_cnt_hi;
  logic       alt_tick;
  logic       tick_lo;
  logic       tick_hi;
  logic       inc_lo;
  logic       inc_hi;
  logic       wrap_lo;
  logic       wrap_hi;
  logic       reload_lo_on_wrap;
  logic [7:0] count_lo;
  logic [7:0] count_hi;
  logic [7:0] ctrl_view;

  assign wr_ctrl   = sfr_req.wr && (sfr_req.addr == split_timer_pkg::CONTROL_ADDR);
  assign wr_cnt_lo = sfr_req.wr && (sfr_req.addr == split_timer_pkg::COUNT_LOW_ADDR);
  assign wr_cnt_hi = sfr_req.wr && (sfr_req.addr == split_timer_pkg::COUNT_HIGH_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // clock enables

  // system clock / 12 as a one-cycle enable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sys_div_reg  <= 4'h0;
      sys_tick_reg <= 1'b0;
    end
    else
    begin
      sys_tick_reg <= (sys_div_reg == split_timer_pkg::SYS_DIV_LAST);
      sys_div_reg  <= (sys_div_reg == split_timer_pkg::SYS_DIV_LAST) ? 4'h0 : sys_div_reg + 4'h1;
    end
  end

  // the oscillator pin is asynchronous: two flops before the edge detector
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      ext_meta_reg <= ext_osc_clk;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  // divide synchronised rising edges by 8; edges faster than clk are lost
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_div_reg  <= 3'h0;
      ext_tick_reg <= 1'b0;
    end
    else
    begin
      ext_tick_reg <= 1'b0;
      if (ext_sync_reg && !ext_prev_reg)
      begin
        ext_div_reg  <= ext_div_reg + 3'h1;
        ext_tick_reg <= (ext_div_reg == split_timer_pkg::EXT_DIV_LAST);
      end
    end
  end

  // alternate clock and per-byte selection
  assign alt_tick = xclk_reg ? ext_tick_reg : sys_tick_reg;
  assign tick_lo  = low_byte_clock_select ? 1'b1 : alt_tick;
  assign tick_hi  = split_reg ? (high_byte_clock_select ? 1'b1 : alt_tick)
                              : tick_lo;

  ////////////////////////////////////////////////////////////////////////////
  // counter bytes

  // in 16-bit mode the high byte steps on low wrap; in split mode the low byte free-runs
  assign inc_lo = split_reg ? tick_lo : (run_reg && tick_lo);
  assign inc_hi = split_reg ? (run_reg && tick_hi) : (inc_lo && !wr_cnt_lo
                  && (count_lo == split_timer_pkg::BYTE_MAX));
  // low byte reloads alone in split mode, or with the high byte on full rollover
  assign reload_lo_on_wrap = split_reg || (count_hi == split_timer_pkg::BYTE_MAX);

  reload_byte_counter low_byte
  (
    .clk          (clk),
    .rst          (rst),
    .inc          (inc_lo),
    .wrap_reload  (reload_lo_on_wrap),
    .load         (wr_cnt_lo),
    .load_value   (sfr_req.wdata),
    .reload_value (reload_low_reg),
    .count        (count_lo),
    .wrap         (wrap_lo)
  );

  reload_byte_counter high_byte
  (
    .clk          (clk),
    .rst          (rst),
    .inc          (inc_hi),
    .wrap_reload  (1'b1),
    .load         (wr_cnt_hi),
    .load_value   (sfr_req.wdata),
    .reload_value (reload_high_reg),
    .count        (count_hi),
    .wrap         (wrap_hi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control and reload registers

  // configuration bits; bits 4 and 1 have no storage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      low_irq_en_reg <= split_timer_pkg::CONTROL_RESET[split_timer_pkg::LOW_IRQ_EN_BIT];
      split_reg      <= split_timer_pkg::CONTROL_RESET[split_timer_pkg::SPLIT_BIT];
      run_reg        <= split_timer_pkg::CONTROL_RESET[split_timer_pkg::RUN_BIT];
      xclk_reg       <= split_timer_pkg::CONTROL_RESET[split_timer_pkg::XCLK_BIT];
    end
    else if (wr_ctrl)
    begin
      low_irq_en_reg <= sfr_req.wdata[split_timer_pkg::LOW_IRQ_EN_BIT];
      split_reg      <= sfr_req.wdata[split_timer_pkg::SPLIT_BIT];
      run_reg        <= sfr_req.wdata[split_timer_pkg::RUN_BIT];
      xclk_reg       <= sfr_req.wdata[split_timer_pkg::XCLK_BIT];
    end
  end

  // sticky flags: an overflow in the write cycle beats a software clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      high_flag_reg <= split_timer_pkg::CONTROL_RESET[split_timer_pkg::HIGH_FLAG_BIT];
      low_flag_reg  <= split_timer_pkg::CONTROL_RESET[split_timer_pkg::LOW_FLAG_BIT];
    end
    else
    begin
      if (wrap_hi)
        high_flag_reg <= 1'b1;
      else if (wr_ctrl)
        high_flag_reg <= sfr_req.wdata[split_timer_pkg::HIGH_FLAG_BIT];
      if (wrap_lo)
        low_flag_reg <= 1'b1;
      else if (wr_ctrl)
        low_flag_reg <= sfr_req.wdata[split_timer_pkg::LOW_FLAG_BIT];
    end
  end

  // reload bytes are plain storage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reload_low_reg  <= split_timer_pkg::RELOAD_RESET;
      reload_high_reg <= split_timer_pkg::RELOAD_RESET;
    end
    else if (sfr_req.wr)
    begin
      if (sfr_req.addr == split_timer_pkg::RELOAD_LOW_ADDR)
        reload_low_reg <= sfr_req.wdata;
      if (sfr_req.addr == split_timer_pkg::RELOAD_HIGH_ADDR)
        reload_high_reg <= sfr_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port and interrupt

  assign ctrl_view = {high_flag_reg, low_flag_reg, low_irq_en_reg, 1'b0,
                      split_reg, run_reg, 1'b0, xclk_reg};

  // read data registered one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (sfr_req.rd)
    begin
      unique case (sfr_req.addr)
        split_timer_pkg::CONTROL_ADDR:     rdata_reg <= ctrl_view;
        split_timer_pkg::RELOAD_LOW_ADDR:  rdata_reg <= reload_low_reg;
        split_timer_pkg::RELOAD_HIGH_ADDR: rdata_reg <= reload_high_reg;
        split_timer_pkg::COUNT_LOW_ADDR:   rdata_reg <= count_lo;
        split_timer_pkg::COUNT_HIGH_ADDR:  rdata_reg <= count_hi;
        default:                           rdata_reg <= 8'h00;
      endcase
    end
  end

  // level request; the core must clear the flags, vectoring does not
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= timer_irq_enable && (high_flag_reg
                 || (low_irq_en_reg && low_flag_reg));
  end

  assign sfr_rdata = rdata_reg;
  assign timer_irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_full_roll;
    !split_reg && wrap_hi && wrap_lo && !wr_cnt_hi;
  endsequence

  sequence s_sys_quiet;
    !sys_tick_reg [*8];
  endsequence

  a_full_reload : assert property (s_full_roll |=> {count_hi, count_lo}
    == {$past(reload_high_reg), $past(reload_low_reg)} && high_flag_reg)
    else $error("16-bit rollover did not reload and flag");

  a_div12_gap : assert property (sys_tick_reg |=> s_sys_quiet)
    else $error("divide by 12 enable came too soon");

  a_high_gated : assert property (!run_reg && !wr_cnt_hi |=> $stable(count_hi))
    else $error("high byte moved while stopped");

  // a reload of 0xFF leaves the byte unchanged on wrap, so the step is checked exactly
  a_low_free_run : assert property (split_reg && tick_lo && !wr_cnt_lo
    |=> count_lo == (($past(count_lo) == split_timer_pkg::BYTE_MAX) ? $past(reload_low_reg)
                     : $past(count_lo) + 8'h01))
    else $error("low byte did not step in split mode");

  a_low_flag_set : assert property (wrap_lo |=> low_flag_reg)
    else $error("low overflow flag not set");

  a_flag_sticky : assert property (high_flag_reg && !wr_ctrl |=> high_flag_reg)
    else $error("high overflow flag cleared without a write");

  a_reserved_zero : assert property (sfr_req.rd && sfr_req.addr ==
    split_timer_pkg::CONTROL_ADDR |=> sfr_rdata[4] == 1'b0 && sfr_rdata[1] == 1'b0)
    else $error("unused control bits read nonzero");

  a_irq_follow : assert property (timer_irq_enable && high_flag_reg |=> timer_irq)
    else $error("irq missing while high flag set");

  a_irq_drop : assert property (!high_flag_reg && !low_flag_reg |=> !timer_irq)
    else $error("irq high with no flag set");

  a_ext_tick_cause : assert property (ext_tick_reg |-> $past(ext_sync_reg)
    && !$past(ext_prev_reg))
    else $error("external tick without synchronised edge");

endmodule : split_autoreload_timer

`default_nettype wire

// ==== hw/README_none.sv ====
`default_nettype none
`default_nettype wire

// ==== dv/cpu_core_model.sv ====
`default_nettype none

// core side of the register bus, plus the board oscillator
module cpu_core_model
(
  input  wire logic                 clk,
  input  wire logic           [7:0] sfr_rdata,
  output split_timer_pkg::sfr_req_s sfr_req,
  output logic                      ext_osc_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // oscillator at a quarter of the system rate, so the sync never aliases
  initial
  begin
    sfr_req     = '0;
    ext_osc_clk = 1'b0;
    forever #20 ext_osc_clk = ~ext_osc_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // strobes last exactly one edge; idle lines flip so stale data never matches
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1 sfr_req = '{1'b1, 1'b0, addr, data};
    @(posedge clk);
    #1 sfr_req = '{1'b0, 1'b0, ~addr, ~data};
  endtask : write_reg

  // read data is registered on the taking edge and sampled one cycle later
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    #1 sfr_req = '{1'b0, 1'b1, addr, 8'h00};
    @(posedge clk);
    #1 sfr_req = '{1'b0, 1'b0, ~addr, 8'hFF};
    @(posedge clk);
    #1 data = sfr_rdata;
  endtask : read_reg

endmodule : cpu_core_model

`default_nettype wire

// ==== dv/tb_top.sv ====
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_s;

  logic                      clk;
  logic                      rst;
  logic                      irq_en;
  logic                      hi_sel;
  logic                      lo_sel;
  logic                      ext_clk;
  logic                      irq;
  logic                [7:0] rdata;
  logic                [7:0] v;
  split_timer_pkg::sfr_req_s req;
  int                        num_errors = 0;
  int                        checked = 0;
  // timer stopped, so counts hold what was written; 0xC9 is unmapped
  row_s rows [6] = '{'{8'hC8, 8'h13, 8'h01}, '{8'hCA, 8'h5A, 8'h5A},
                     '{8'hCB, 8'hA5, 8'hA5}, '{8'hCC, 8'h3C, 8'h3C},
                     '{8'hCD, 8'hC3, 8'hC3}, '{8'hC9, 8'h77, 8'h00}};

  split_autoreload_timer split_autoreload_timer_i (
    .clk                    (clk),
    .rst                    (rst),
    .sfr_req                (req),
    .timer_irq_enable       (irq_en),
    .high_byte_clock_select (hi_sel),
    .low_byte_clock_select  (lo_sel),
    .ext_osc_clk            (ext_clk),
    .sfr_rdata              (rdata),
    .timer_irq              (irq)
  );

  cpu_core_model cpu_core_model_i (
    .clk         (clk),
    .sfr_rdata   (rdata),
    .sfr_req     (req),
    .ext_osc_clk (ext_clk)
  );

  // system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // range compare; an unknown never lands inside the range
  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    checked++;
    if (((got >= lo) && (got <= hi)) !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    cpu_core_model_i.read_reg(a, v);
    chk(v, lo, hi);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu_core_model_i.write_reg(a, d);
  endtask : wr

  // poll control until all mask bits are set; bounded so a dead timer ends the run
  task automatic wait_flag(input logic [7:0] mask);
    for (int i = 0; i < 400; i++)
    begin
      cpu_core_model_i.read_reg(8'hC8, v);
      if ((v & mask) === mask)
        return;
    end
    num_errors++;
    $display("[FAIL] %0t flag wait timed out", $time);
    stop_test();
  endtask : wait_flag

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst    = 1'b1;
    irq_en = 1'b0;
    hi_sel = 1'b0;
    lo_sel = 1'b1;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    // register table, reserved control bits and the unmapped address
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp, rows[i].exp);
    end
    // second reset in mid-run clears everything
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    foreach (rows[i])
      rd(rows[i].addr, 8'h00, 8'h00);
    // 16-bit wrap from 0xFFFF on the system clock
    wr(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    wait_flag(8'hC0);
    wr(8'hC8, 8'hC0);
    rd(8'hCD, 8'h12, 8'h12);
    rd(8'hCC, 8'h34, 8'h4F);
    chk({7'h00, irq}, 8'h00, 8'h00);
    irq_en = 1'b1;
    repeat (20) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h01, 8'h01);
    rd(8'hC8, 8'hC0, 8'hC0);
    wr(8'hC8, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00, 8'h00);
    // split mode, high byte stopped, low byte free-running with its own irq
    hi_sel = 1'b1;
    wr(8'hCA, 8'h80);
    wr(8'hCB, 8'hF0);
    wr(8'hCD, 8'hFE);
    wr(8'hCC, 8'hFD);
    wr(8'hC8, 8'h28);
    wait_flag(8'h40);
    rd(8'hCD, 8'hFE, 8'hFE);
    rd(8'hCC, 8'h80, 8'hFF);
    chk({7'h00, irq}, 8'h01, 8'h01);
    wr(8'hC8, 8'h2C);
    wait_flag(8'hC0);
    rd(8'hCD, 8'hF0, 8'hFF);
    // divide-12 clock; high select must not matter in 16-bit mode
    lo_sel = 1'b0;
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h04);
    repeat (120) @(posedge clk);
    wr(8'hC8, 8'h00);
    rd(8'hCC, 8'h09, 8'h0B);
    rd(8'hCD, 8'h00, 8'h00);
    // synchronised external clock, one step every 32 system cycles
    wr(8'hCC, 8'h00);
    wr(8'hC8, 8'h05);
    repeat (320) @(posedge clk);
    wr(8'hC8, 8'h01);
    rd(8'hCC, 8'h08, 8'h0B);
    // split mode with both bytes on the divide-12 alternate clock
    hi_sel = 1'b0;
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h0C);
    repeat (120) @(posedge clk);
    wr(8'hC8, 8'h08);
    rd(8'hCD, 8'h09, 8'h0B);
    rd(8'hCC, 8'h09, 8'h0B);
    stop_test();
  end

endmodule : tb_top

`default_nettype wire
